// ---- common/rbs_pkg.sv ----
// constants, types and field layout of the battery-backed sram clock port
// Operation
// - 524,288 bytes, one picked by 19 address lines
// - bcd time and calendar bytes, 24-hour clock
// - month lengths and leap years through 2099
// - control byte at top-eight base address
// - time bytes are ram, refreshed once per second
// - time and control bytes use normal bus cycles
// - read when selected, write enable high
// - deselect floats data lines, ignores other controls
// - data valid after latest access delay
// - write spans overlap of enable and select
// - write enable low releases driven data lines
// - power fail deselects and blocks writes
// - power fail corrupts at most written byte
// - battery below switchover, supply above it
// - block accesses until recovery delay elapses
// - halt bit freezes time bytes
// - refresh is one cycle, never cut short
// - halt leaves counters running
// - refresh resumes one second after halt clears
// - load bit writes time bytes into counters
// - reset clears load and halt bits
// - stop bit halts oscillator, restart after second
package rbs_pkg;

  // ----------------------------------------------------------------
  // array geometry and clock byte map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 19;        // address lines
  localparam int unsigned MEM_DEPTH = 524288;    // bytes in the array
  localparam logic [18:0] CTRL_ADDR = 19'h7fff8; // clock control byte
  localparam logic [2:0]  IDX_SEC   = 3'h1;      // seconds, low bits 001
  localparam logic [2:0]  IDX_MIN   = 3'h2;      // minutes
  localparam logic [2:0]  IDX_HOUR  = 3'h3;      // hours
  localparam logic [2:0]  IDX_DOW   = 3'h4;      // day of week
  localparam logic [2:0]  IDX_DATE  = 3'h5;      // date of month
  localparam logic [2:0]  IDX_MON   = 3'h6;      // month
  localparam logic [2:0]  IDX_YEAR  = 3'h7;      // year

  // ----------------------------------------------------------------
  // field positions and limits
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_LOAD_BIT = 7;        // load bit
  localparam int unsigned CTRL_HALT_BIT = 6;        // refresh halt bit
  localparam int unsigned STOP_BIT      = 7;        // in the seconds byte
  localparam logic [7:0]  CTRL_RESET    = 8'h00;    // load, halt, cal clear
  localparam logic [7:0]  FIELD_MASK [1:7] =
    '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};
  localparam logic [7:0]  FIELD_MIN  [1:7] =
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0]  FIELD_MAX  [1:7] =
    '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125000000; // system clock
  localparam int unsigned CLK_NS        = 8;         // its period
  localparam int unsigned ADDR_ACC_NS   = 70;        // address access, longest
  localparam int unsigned OUT_HOLD_NS   = 10;        // output hold, least
  localparam int unsigned WR_REL_NS     = 25;        // write release, longest
  localparam int unsigned RECOVERY_MS   = 40;        // power-up recovery, least
  localparam int unsigned ADDR_ACC_CYC  = ADDR_ACC_NS / CLK_NS;
  localparam int unsigned OUT_HOLD_CYC  = (OUT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WR_REL_CYC    = WR_REL_NS / CLK_NS;
  localparam int unsigned ONE_SEC_CYC   = CLK_HZ;
  localparam int unsigned RECOVERY_CYC  = RECOVERY_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // sampled bus pins travel together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ce_n;   // chip select
    logic        oe_n;   // output enable
    logic        we_n;   // write enable
    logic [18:0] addr;   // address lines
    logic [7:0]  data;   // data lines in
  } rbs_pins_t;

  localparam rbs_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 19'h00000, 8'h00};

endpackage

// ---- hw/rbs_div.sv ----
// restartable period divider giving a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module rbs_div #(
  parameter int unsigned PERIOD = 2  // cycles between ticks
) (
  input  wire logic clk_in,      // system clock
  input  wire logic nrst_in,     // async reset, low
  input  wire logic restart_in,  // restart a full period
  input  wire logic enable_in,   // count only while high
  output logic      tick_out     // one-cycle pulse per period
);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [31:0] count;  // cycles into the period

  // restart wins, so a period always starts clean
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count    <= 32'h00000000;
      tick_out <= 1'b0;
    end else if (restart_in) begin
      count    <= 32'h00000000;
      tick_out <= 1'b0;
    end else if (enable_in) begin
      if (count == PERIOD - 1) begin  // period complete
        count    <= 32'h00000000;
        tick_out <= 1'b1;
      end else begin
        count    <= count + 32'h00000001;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;  // paused, counts held
    end
  end

endmodule
`default_nettype wire

// ---- hw/rbs_rtc_sram.sv ----
// byte-wide static ram with battery-backed calendar clock in its top bytes
`timescale 1ns/1ps
`default_nettype none
module rbs_rtc_sram #(
  parameter int unsigned ONE_SEC_CYC  = rbs_pkg::ONE_SEC_CYC,  // one second
  parameter int unsigned RECOVERY_CYC = rbs_pkg::RECOVERY_CYC  // power-up wait
) (
  input  wire logic        clk_in,              // system clock
  input  wire logic        nrst_in,             // async reset, low
  input  wire logic [18:0] addr_lines_in,       // address pins
  input  wire logic [7:0]  data_lines_in,       // data pins, inbound
  input  wire logic        ce_n_in,             // chip select, low
  input  wire logic        oe_n_in,             // output enable, low
  input  wire logic        we_n_in,             // write enable, low
  input  wire logic        vcc_ok_in,           // supply above fail threshold
  input  wire logic        vcc_above_so_in,     // supply above switchover
  output logic      [7:0]  data_lines_out,      // data pins, outbound
  output logic             data_lines_oe_n_out, // low while driving
  output logic             battery_select_out   // high while on battery
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // next bcd value of one calendar field, wrapping at its limit
  function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] vmax,
                                          input logic [7:0] vmin);
    logic [3:0] tens;
    tens = v[7:4] + 4'h1;
    if (v == vmax) begin
      bcd_next = vmin;
    end else if (v[3:0] == 4'h9) begin
      bcd_next = {tens, 4'h0};
    end else begin
      bcd_next = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last bcd date of a month; year 00 counts as leap, good to 2099
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02:                      month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default:                    month_end = 8'h31;
    endcase
  endfunction

  // true for the eight clock bytes at the top of the array
  function automatic logic is_clock_byte(input logic [18:0] a);
    is_clock_byte = (a[18:3] == rbs_pkg::CTRL_ADDR[18:3]);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  rbs_pkg::rbs_pins_t pin_meta;  // first stage, read by second only
  rbs_pkg::rbs_pins_t pin_s;     // synchronised pins
  logic [1:0]         pwr_meta;  // power sense, first stage
  logic [1:0]         pwr_s;     // {above switchover, supply ok}

  // pins come from another domain, two flops before any use
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_meta <= rbs_pkg::PINS_IDLE;
      pin_s    <= rbs_pkg::PINS_IDLE;
      pwr_meta <= 2'h0;
      pwr_s    <= 2'h0;
    end else begin
      pin_meta <= '{ce_n_in, oe_n_in, we_n_in, addr_lines_in, data_lines_in};
      pin_s    <= pin_meta;
      pwr_meta <= {vcc_above_so_in, vcc_ok_in};
      pwr_s    <= pwr_meta;
    end
  end

  // ----------------------------------------------------------------
  // power fail and recovery
  // ----------------------------------------------------------------
  logic recovered;  // recovery delay served since supply came good
  logic rec_tick;   // recovery delay expired
  logic blocked;    // device deselected and write protected

  assign blocked = !pwr_s[0] || !recovered;

  rbs_div #(.PERIOD(RECOVERY_CYC)) u_rec_div (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .restart_in (!pwr_s[0]),
    .enable_in  (!recovered),
    .tick_out   (rec_tick)
  );

  // reset counts as power-up, so a full recovery wait follows it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      recovered <= 1'b0;
    end else if (!pwr_s[0]) begin
      recovered <= 1'b0;
    end else if (rec_tick) begin
      recovered <= 1'b1;
    end
  end

  // supply source follows switchover sense; clock logic never stops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      battery_select_out <= 1'b1;
    end else begin
      battery_select_out <= !pwr_s[1];
    end
  end

  // ----------------------------------------------------------------
  // write engine
  // ----------------------------------------------------------------
  logic        wr_act;    // select and write enable both low
  logic        wr_act_q;  // previous cycle's wr_act
  logic [18:0] wr_addr;   // address held during the write
  logic [7:0]  wr_data;   // last data seen before the write ended
  logic        commit;    // write ended cleanly this cycle

  // later falling edge opens the window, earlier rising edge closes it
  assign wr_act = !blocked && !pin_s.ce_n && !pin_s.we_n;
  // a write cut by power fail is dropped: only that byte is lost
  assign commit = wr_act_q && !wr_act && !blocked;

  // address held steady by the host for the whole write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_act_q <= 1'b0;
      wr_addr  <= 19'h00000;
      wr_data  <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_addr <= pin_s.addr;
        wr_data <= pin_s.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:rbs_pkg::MEM_DEPTH-1];  // plain ram cells
  logic [7:0] ctrl;                          // clock control byte
  logic [7:0] tbyte [1:7];                   // user-visible time bytes
  logic [7:0] cnt [1:7];                     // real clock counters
  logic       osc_stop;                      // stop bit copy

  // no reset: contents are kept across resets like battery-backed ram
  always_ff @(posedge clk_in) begin
    if (commit && !is_clock_byte(wr_addr)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // control byte, halt and load
  // ----------------------------------------------------------------
  logic halt;       // refresh held off by halt or load bit
  logic halt_q;     // previous halt
  logic load_rel;   // load bit cleared by a write this cycle
  logic ctrl_wr;    // commit to the control byte

  assign ctrl_wr  = commit && (wr_addr == rbs_pkg::CTRL_ADDR);
  assign load_rel = ctrl_wr && ctrl[rbs_pkg::CTRL_LOAD_BIT]
                    && !wr_data[rbs_pkg::CTRL_LOAD_BIT];
  assign halt     = ctrl[rbs_pkg::CTRL_HALT_BIT] || ctrl[rbs_pkg::CTRL_LOAD_BIT];

  // calibration bits are stored only; trimming is not modelled
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl   <= rbs_pkg::CTRL_RESET;
      halt_q <= 1'b0;
    end else begin
      halt_q <= halt;
      if (ctrl_wr) begin
        ctrl <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // oscillator and tick dividers
  // ----------------------------------------------------------------
  logic osc_run;    // oscillator running
  logic osc_tick;   // start-up delay done
  logic sec_tick;   // counters advance one second
  logic ref_tick;   // time bytes due for refresh
  logic ref_rst;    // restart refresh timing

  // after a halt or load ends, the next refresh is a full second away
  assign ref_rst = (halt_q && !halt) || load_rel;

  rbs_div #(.PERIOD(ONE_SEC_CYC)) u_osc_div (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .restart_in (osc_stop),
    .enable_in  (!osc_run),
    .tick_out   (osc_tick)
  );

  rbs_div #(.PERIOD(ONE_SEC_CYC)) u_sec_div (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .restart_in (load_rel),
    .enable_in  (osc_run),
    .tick_out   (sec_tick)
  );

  rbs_div #(.PERIOD(ONE_SEC_CYC)) u_ref_div (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .restart_in (ref_rst),
    .enable_in  (1'b1),
    .tick_out   (ref_tick)
  );

  // stop bit stops at once; a cleared bit restarts a second later
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_run <= 1'b1;
    end else if (osc_stop) begin
      osc_run <= 1'b0;
    end else if (osc_tick) begin
      osc_run <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // clock counters
  // ----------------------------------------------------------------
  logic [7:0] next_cnt [1:7];  // counters after one second
  logic [7:0] mend;            // last date of current month

  // carry ripples only through fields whose predecessor wrapped
  always_comb begin
    mend = month_end(cnt[rbs_pkg::IDX_MON], cnt[rbs_pkg::IDX_YEAR]);
    for (int i = 1; i <= 7; i++) next_cnt[i] = cnt[i];
    next_cnt[1] = bcd_next(cnt[1], rbs_pkg::FIELD_MAX[1], rbs_pkg::FIELD_MIN[1]);
    if (cnt[1] == rbs_pkg::FIELD_MAX[1]) begin
      next_cnt[2] = bcd_next(cnt[2], rbs_pkg::FIELD_MAX[2], rbs_pkg::FIELD_MIN[2]);
      if (cnt[2] == rbs_pkg::FIELD_MAX[2]) begin
        next_cnt[3] = bcd_next(cnt[3], rbs_pkg::FIELD_MAX[3], rbs_pkg::FIELD_MIN[3]);
        if (cnt[3] == rbs_pkg::FIELD_MAX[3]) begin
          next_cnt[4] = bcd_next(cnt[4], rbs_pkg::FIELD_MAX[4], rbs_pkg::FIELD_MIN[4]);
          next_cnt[5] = bcd_next(cnt[5], mend, rbs_pkg::FIELD_MIN[5]);
          if (cnt[5] == mend) begin
            next_cnt[6] = bcd_next(cnt[6], rbs_pkg::FIELD_MAX[6], rbs_pkg::FIELD_MIN[6]);
            if (cnt[6] == rbs_pkg::FIELD_MAX[6]) begin
              next_cnt[7] = bcd_next(cnt[7], rbs_pkg::FIELD_MAX[7], rbs_pkg::FIELD_MIN[7]);
            end
          end
        end
      end
    end
  end

  // counters ignore halt; only a load or a tick changes them
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 1; i <= 7; i++) cnt[i] <= rbs_pkg::FIELD_MIN[i];
    end else if (load_rel) begin
      for (int i = 1; i <= 7; i++) begin
        cnt[i] <= tbyte[i] & rbs_pkg::FIELD_MASK[i];
      end
    end else if (sec_tick) begin
      for (int i = 1; i <= 7; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // time bytes
  // ----------------------------------------------------------------
  // whole set refreshed in one cycle, so a halt cannot split it;
  // a host write in the same cycle lands after the refresh
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 1; i <= 7; i++) tbyte[i] <= rbs_pkg::FIELD_MIN[i];
      osc_stop <= 1'b0;
    end else begin
      if (ref_tick && !halt) begin
        for (int i = 1; i <= 7; i++) begin
          tbyte[i] <= cnt[i];
        end
        tbyte[rbs_pkg::IDX_SEC][rbs_pkg::STOP_BIT] <= osc_stop;
      end
      if (commit && is_clock_byte(wr_addr) && wr_addr[2:0] != 3'h0) begin
        tbyte[wr_addr[2:0]] <= wr_data;
        if (wr_addr[2:0] == rbs_pkg::IDX_SEC) begin
          osc_stop <= wr_data[rbs_pkg::STOP_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read path and output drive
  // ----------------------------------------------------------------
  logic [7:0]  rd_data;   // byte at the synchronised address
  logic        rd_mode;   // selected with write enable high
  logic        drive;     // data lines should be driven
  logic [18:0] addr_q;    // address of previous cycle
  logic [3:0]  acc_cnt;   // cycles since address change or turn-on
  logic [1:0]  rel_cnt;   // cycles since write enable fell

  // clock bytes are read through the same path as the ram
  always_comb begin
    if (!is_clock_byte(pin_s.addr)) begin
      rd_data = mem[pin_s.addr];
    end else if (pin_s.addr[2:0] == 3'h0) begin
      rd_data = ctrl;
    end else begin
      rd_data = tbyte[pin_s.addr[2:0]];
    end
  end

  assign rd_mode = !blocked && !pin_s.ce_n && pin_s.we_n;
  // write enable low on a bus already driven lets go after a short delay;
  // an undriven bus stays off, so select and write falling together never drive
  assign drive = !blocked && !pin_s.ce_n && !pin_s.oe_n && (rd_mode
                 || (!data_lines_oe_n_out && rel_cnt < 2'(rbs_pkg::WR_REL_CYC)));

  // access and release timing counters
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_q  <= 19'h00000;
      acc_cnt <= 4'h0;
      rel_cnt <= 2'h0;
    end else begin
      addr_q <= pin_s.addr;
      if (!drive || pin_s.addr != addr_q) begin
        acc_cnt <= 4'h0;
      end else if (acc_cnt != 4'hf) begin
        acc_cnt <= acc_cnt + 4'h1;
      end
      if (pin_s.we_n) begin
        rel_cnt <= 2'h0;
      end else if (rel_cnt != 2'h3) begin
        rel_cnt <= rel_cnt + 2'h1;
      end
    end
  end

  // old data holds briefly, then junk until the address access is met;
  // zero stands for the undefined value during that gap
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_lines_out      <= 8'h00;
      data_lines_oe_n_out <= 1'b1;
    end else begin
      data_lines_oe_n_out <= !drive;
      if (acc_cnt >= 4'(rbs_pkg::ADDR_ACC_CYC - 1)) begin
        data_lines_out <= rd_data;
      end else if (acc_cnt >= 4'(rbs_pkg::OUT_HOLD_CYC - 1)) begin
        data_lines_out <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verification/rbs_rtc_sram_properties.sv ----
// pin-level assertions for the sram clock port
`timescale 1ns/1ps
`default_nettype none
module rbs_rtc_sram_properties #(
  parameter int unsigned ONE_SEC_CYC  = 20, // one second
  parameter int unsigned RECOVERY_CYC = 10  // power-up wait
) (
  input wire logic clk_in,              // clock
  input wire logic nrst_in,             // reset, low
  input wire logic ce_n_in,             // select
  input wire logic oe_n_in,             // output enable
  input wire logic we_n_in,             // write enable
  input wire logic vcc_ok_in,           // supply good
  input wire logic vcc_above_so_in,     // above switchover
  input wire logic data_lines_oe_n_out, // drive, low
  input wire logic battery_select_out   // on battery
);
  // ----------------------------------------------------------------
  // supply-good counter; ready keeps a margin for the input syncs
  // ----------------------------------------------------------------
  int unsigned up_cnt; // saturating count
  logic        ready;  // recovery surely over
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt <= 0;
    end else if (!vcc_ok_in) begin
      up_cnt <= 0;
    end else if (up_cnt < RECOVERY_CYC + 9) begin
      up_cnt <= up_cnt + 1;
    end
  end
  assign ready = up_cnt > RECOVERY_CYC + 7;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_DESEL: assert property (ce_n_in [*5] |-> data_lines_oe_n_out)
    else $error("drive while deselected");
  AST_READ: assert property ((ready && !ce_n_in && !oe_n_in && we_n_in) [*5] |->
    !data_lines_oe_n_out) else $error("read not driven");
  AST_OE_FALL: assert property ($fell(data_lines_oe_n_out) |-> !$past(ce_n_in, 3) &&
    !$past(oe_n_in, 3) && $past(we_n_in, 3)) else $error("drive without read");
  AST_WE_REL: assert property ((!we_n_in) [*8] |-> data_lines_oe_n_out)
    else $error("drive during write");
  AST_PF: assert property ((!vcc_ok_in) [*5] |-> data_lines_oe_n_out)
    else $error("drive in power fail");
  AST_RECOV: assert property (up_cnt >= 4 && up_cnt < RECOVERY_CYC |->
    data_lines_oe_n_out) else $error("drive during recovery");
  AST_BAT_ON: assert property ((!vcc_above_so_in) [*5] |-> battery_select_out)
    else $error("not on battery");
  AST_BAT_OFF: assert property (vcc_above_so_in [*5] |-> !battery_select_out)
    else $error("battery kept");
endmodule
bind rbs_rtc_sram rbs_rtc_sram_properties #(.ONE_SEC_CYC(ONE_SEC_CYC),
  .RECOVERY_CYC(RECOVERY_CYC)) i_props (.clk_in(clk_in), .nrst_in(nrst_in),
  .ce_n_in(ce_n_in), .oe_n_in(oe_n_in), .we_n_in(we_n_in), .vcc_ok_in(vcc_ok_in),
  .vcc_above_so_in(vcc_above_so_in), .data_lines_oe_n_out(data_lines_oe_n_out),
  .battery_select_out(battery_select_out));
`default_nettype wire

// ---- verification/rbs_host.sv ----
// host model driving the sram clock port pins at falling edges
`timescale 1ns/1ps
`default_nettype none
module rbs_host (
  input  wire logic        clk_in,   // clock
  input  wire logic [7:0]  data_in,  // resolved data lines
  input  wire logic        drv_n_in, // device drives, low
  output logic             ce_n_out, // select
  output logic             oe_n_out, // output enable
  output logic             we_n_out, // write enable
  output logic      [18:0] addr_out, // address
  output logic      [7:0]  data_out  // host data
);
  initial begin
    {ce_n_out, oe_n_out, we_n_out, addr_out, data_out} = {3'h7, 19'h00000, 8'h00};
  end
  // output enable stays high through writes, so no bus contention
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {addr_out, data_out, ce_n_out, we_n_out} = {a, d, 2'b00};
    repeat (8) @(negedge clk_in);
    {ce_n_out, we_n_out} = 2'b11;
    repeat (2) @(negedge clk_in);
    data_out = ~d; // released: inverted, never the stale byte
    repeat (2) @(negedge clk_in);
  endtask
  // bounded wait for drive, then the access delay before sampling
  task automatic rd(input logic [18:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(negedge clk_in);
    {addr_out, ce_n_out, oe_n_out} = {a, 2'b00};
    for (n = 0; n < 20 && drv_n_in !== 1'b0; n++) @(negedge clk_in);
    ok = n < 20;
    repeat (12) @(negedge clk_in);
    d = data_in;
    {ce_n_out, oe_n_out} = 2'b11;
    repeat (3) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ---- verification/rbs_rtc_sram_tb.sv ----
// self-checking bench for the sram clock port
`timescale 1ns/1ps
`default_nettype none
module rbs_rtc_sram_tb;
  localparam int unsigned SEC = 400; // shortened second
  localparam int unsigned REC = 10;  // shortened recovery
  // calendar cases, bytes year down to seconds: plain feb, then leap feb
  localparam logic [55:0] SET_V [2] = '{56'h01022807235959, 56'h04022803235959};
  localparam logic [55:0] EXP_V [2] = '{56'h01030101000000, 56'h04022904000000};
  logic        clk_in, nrst_in, vcc_ok, vcc_so; // clock, reset, supply
  logic        ce_n, oe_n, we_n, drv_n, batt;   // bus controls, status
  logic [18:0] addr;                            // address
  logic [7:0]  hd, dout, bus;                   // host, device, wire
  int          mismatches, n_tests;             // counters
  assign bus = drv_n ? hd : dout; // device wins while it drives
  rbs_rtc_sram #(.ONE_SEC_CYC(SEC), .RECOVERY_CYC(REC)) i_dut (.clk_in(clk_in),
    .nrst_in(nrst_in), .addr_lines_in(addr), .data_lines_in(bus), .ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .vcc_ok_in(vcc_ok), .vcc_above_so_in(vcc_so),
    .data_lines_out(dout), .data_lines_oe_n_out(drv_n), .battery_select_out(batt));
  rbs_host i_host (.clk_in(clk_in), .data_in(bus), .drv_n_in(drv_n), .ce_n_out(ce_n),
    .oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr), .data_out(hd));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // checking tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // a read that never gets driven ends the run
  task automatic rchk(input logic [18:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    i_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no drive at %h", $time, a);
      results();
    end else chk(d, e);
  endtask
  // reset doubles as power-up, so recovery is waited out as well
  task automatic boot();
    nrst_in = 1'b0;
    vcc_ok = 1'b1;
    repeat (3) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4 * REC) @(negedge clk_in);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    n_tests = 0;
    vcc_so = 1'b1;
    boot();
    chk({7'h00, batt}, 8'h00);
    i_host.wr(19'h00000, 8'h5a);
    i_host.wr(19'h7fff7, 8'ha5);
    rchk(19'h00000, 8'h5a);
    rchk(19'h7fff7, 8'ha5);
    // load a time just before midnight, let one second pass, freeze, read
    for (int k = 0; k < 2; k++) begin
      i_host.wr(19'h7fff8, 8'h80);
      for (int i = 1; i < 8; i++) i_host.wr({16'hffff, 3'(i)}, SET_V[k][8*i-8 +: 8]);
      i_host.wr(19'h7fff8, 8'h00);
      repeat (SEC + SEC / 2) @(negedge clk_in);
      i_host.wr(19'h7fff8, 8'h40);
      rchk(19'h7fff8, 8'h40);
      for (int i = 1; i < 8; i++) rchk({16'hffff, 3'(i)}, EXP_V[k][8*i-8 +: 8]);
      repeat (2 * SEC) @(negedge clk_in);
      rchk(19'h7fff9, 8'h00);
    end
    // stop bit loaded with seconds 00: a refresh must show 80, stop bit set and seconds still 00
    i_host.wr(19'h7fff8, 8'h80);
    i_host.wr(19'h7fff9, 8'h80);
    i_host.wr(19'h7fff8, 8'h00);
    repeat (SEC + SEC / 2) @(negedge clk_in);
    i_host.wr(19'h7fff8, 8'h40);
    rchk(19'h7fff9, 8'h80);
    // supply loss: the write must be ignored and battery taken
    i_host.wr(19'h00100, 8'h3c);
    vcc_ok = 1'b0;
    vcc_so = 1'b0;
    i_host.wr(19'h00100, 8'hc3);
    chk({7'h00, batt}, 8'h01);
    vcc_so = 1'b1;
    vcc_ok = 1'b1;
    repeat (4 * REC) @(negedge clk_in);
    rchk(19'h00100, 8'h3c);
    boot();
    rchk(19'h7fff8, 8'h00);
    results();
  end
endmodule
`default_nettype wire
